// ### src/afmf_pkg.sv
// Package of constants, codes and shared functions for the axis feedback and master filter
`default_nettype none

package afmf_pkg;

    // ------------------------------------------------------------
    // Clock and servo interrupt timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned HZ_PER_MHZ       = 1_000_000;
    localparam int unsigned SERVO_PERIOD_US  = 1000;
    localparam int unsigned SERVO_CYCLES_DEF = SERVO_PERIOD_US * (CLK_HZ / HZ_PER_MHZ);
    localparam int unsigned SLOW_QUEUE_TICKS = 8;
    localparam int unsigned TICK_CNT_W       = 32;
    localparam int unsigned QCNT_W           = 3;

    // ------------------------------------------------------------
    // Register bus and servo variable numbers
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] SV_TTL      = 8'h1C;
    localparam logic [7:0] SV_REF_POS  = 8'h1D;
    localparam logic [7:0] SV_FILT_TC  = 8'h1E;
    localparam logic [7:0] SV_FILT_LIM = 8'h1F;
    localparam logic [7:0] SV_CTRL     = 8'h28;
    localparam logic [7:0] SV_STATUS   = 8'h29;
    localparam logic [7:0] SV_CLOSE    = 8'h2A;

    // ------------------------------------------------------------
    // TTL feedback fields
    // ------------------------------------------------------------
    localparam int unsigned TTL_IN_W  = 24;
    localparam int unsigned TTL_OUT_W = 8;
    localparam int unsigned VALID_BIT = 23;
    localparam int unsigned WAIT_BIT  = 31;

    // ------------------------------------------------------------
    // Control register layout and codes
    // ------------------------------------------------------------
    localparam int unsigned CTRL_W          = 7;
    localparam int unsigned CTRL_AXIS_LSB   = 0;
    localparam int unsigned CTRL_FB_LSB     = 2;
    localparam int unsigned CTRL_POL_BIT    = 4;
    localparam int unsigned CTRL_FASTQ_BIT  = 5;
    localparam int unsigned CTRL_VMODE_BIT  = 6;
    localparam logic [6:0]  CTRL_RESET      = 7'h00;
    localparam logic [1:0]  AXIS_SERVO      = 2'h0;
    localparam logic [1:0]  AXIS_STEPPER    = 2'h1;
    localparam logic [1:0]  AXIS_SERCOS     = 2'h2;
    localparam logic [1:0]  FB_ENCODER      = 2'h0;
    localparam logic [1:0]  FB_RESOLVER     = 2'h1;
    localparam logic [1:0]  FB_ANALOG       = 2'h2;
    localparam logic [1:0]  FB_TTL          = 2'h3;
    localparam int unsigned CLOSE_REQ_BIT   = 0;

    // ------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------
    localparam int unsigned STAT_WAIT_BIT    = 0;
    localparam int unsigned STAT_LOOP_BIT    = 1;
    localparam int unsigned STAT_OK_BIT      = 2;
    localparam int unsigned STAT_REFUSED_BIT = 3;
    localparam int unsigned STAT_REFV_BIT    = 4;
    localparam int unsigned STAT_PEND_BIT    = 5;

    // ------------------------------------------------------------
    // Master filter settings
    // ------------------------------------------------------------
    localparam int unsigned TC_W        = 10;
    localparam int unsigned SHIFT_W     = 4;
    localparam logic [9:0]  TC_RESET    = 10'h000;
    localparam logic [31:0] LIMIT_MAX   = 32'h7FFFFFFF;
    localparam logic [31:0] LIMIT_MIN   = 32'h00000001;
    localparam logic [31:0] LIMIT_RESET = 32'h7FFFFFFF;

    typedef enum logic [2:0] {
        REF_WAIT_SW  = 3'h1,
        REF_WAIT_IDX = 3'h2,
        REF_LATCHED  = 3'h4
    } afmf_ref_state_t;

    // Position in the one fixed count direction
    function automatic logic [31:0] afmf_fb_norm(input logic [31:0] pos, input logic inv);
        return inv ? 32'(-pos) : pos;
    endfunction

    // Time constant 1..1023 to shift 1..10, i.e. effective values 2..1024
    function automatic logic [3:0] afmf_tc_shift(input logic [9:0] tc);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < TC_W; i++)
        begin
            if (tc[i])
                n = 4'(i + 1);
        end
        return n;
    endfunction

endpackage

`default_nettype wire

// ### src/afmf_master_filter.sv
// First-order master delta filter with symmetric lag limit for one slave axis
`default_nettype none

module afmf_master_filter (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               reset_i,
    // Servo interrupt and settings
    input  wire logic               tick_i,
    input  wire logic [9:0]         tc_i,
    input  wire logic [31:0]        limit_i,
    // Master delta in, filtered delta out
    input  wire logic signed [31:0] delta_i,
    output logic signed [31:0]      out_o
);

    logic signed [31:0] lag_q;
    logic signed [31:0] lag_d;
    logic signed [31:0] out_q;
    logic signed [31:0] out_d;
    logic signed [32:0] acc;
    logic signed [32:0] step;
    logic signed [32:0] keep;
    logic signed [32:0] lim;
    logic signed [32:0] diff;
    logic [3:0]         sh;

    always_comb
    begin
        lim   = $signed({1'b0, limit_i});
        acc   = $signed({lag_q[31], lag_q}) + $signed({delta_i[31], delta_i});
        sh    = afmf_pkg::afmf_tc_shift(tc_i);
        step  = acc >>> sh;
        keep  = acc - step;
        // Clamp on both signs; a lowered limit dumps its excess at once
        if (keep > lim)
            keep = lim;
        else if (keep < -lim)
            keep = -lim;
        diff  = acc - keep;
        lag_d = lag_q;
        out_d = out_q;
        if (tick_i)
        begin
            if (tc_i == afmf_pkg::TC_RESET)
                out_d = delta_i;
            else
            begin
                lag_d = keep[31:0];
                out_d = diff[31:0];
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            lag_q <= '0;
            out_q <= '0;
        end
        else
        begin
            lag_q <= lag_d;
            out_q <= out_d;
        end
    end

    assign out_o = out_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_filter_bypass: assert property (
        tick_i && tc_i == afmf_pkg::TC_RESET |=> out_q == $past(delta_i) && $stable(lag_q))
        else $error("zero time constant did not bypass the filter");

    a_lag_within_limit: assert property (
        tick_i && tc_i != afmf_pkg::TC_RESET && $stable(limit_i)
        |=> $signed({lag_q[31], lag_q}) <= $signed({1'b0, limit_i})
            && $signed({lag_q[31], lag_q}) >= -$signed({1'b0, limit_i}))
        else $error("filter lag beyond its error limit");

    a_lag_held_idle: assert property (
        !tick_i |=> $stable(lag_q) && $stable(out_q))
        else $error("filter moved outside a servo interrupt");

endmodule // afmf_master_filter

`default_nettype wire

// ### src/afmf_axis_feedback.sv
// Axis TTL feedback, reference capture, loop close gate and slave master filter
`default_nettype none

// What this block does
// - Reading TTL variable returns the 24 sampled inputs in the low bits.
// - With input 24 as valid marker, bit 31 reports the waiting flag.
// - Waiting flag stays high until valid data arrives, then drops.
// - Loop close request is refused while waiting; succeeds once flag clears.
// - Writing TTL variable drives eight outputs from the low eight data bits.
// - No TTL input or output on stepper or SERCOS axes.
// - Encoder: reference is distance from switch event to index mark.
// - Resolver: reference is absolute position at switch closure.
// - Analog or TTL: reference is absolute position at referencing event.
// - Reference count direction follows the feedback polarity setting.
// - Capture lags up to eight updates, one with fast queuing.
// - No reference capture on stepper axes.
// - Each slave keeps its own master delta filter and settings.
// - Time constant 0..1023; zero bypasses the filter.
// - Time constant maps to effective values 2..1024 in powers of two.
// - At the error limit the filter stops, lag grows no further.
// - Error limit is a positive 1..2147483647, applied to both signs.
// - Queued events act within one interrupt fast, else up to eight.
module afmf_axis_feedback #(
    parameter int unsigned SERVO_CYCLES = afmf_pkg::SERVO_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // Servo variable port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // TTL feedback pins
    input  wire logic [23:0] ttl_in_i,
    output logic      [7:0]  ttl_out_o,
    // Reference and position feedback
    input  wire logic        ref_switch_i,
    input  wire logic        index_mark_i,
    input  wire logic [31:0] fb_pos_i,
    // Master delta and loop
    input  wire logic [31:0] master_delta_i,
    output logic      [31:0] slave_delta_o,
    output logic             loop_closed_o
);

    // ------------------------------------------------------------
    // Servo interrupt divider and queue strobe
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic [31:0] tick_cnt_d;
    logic        tick_q;
    logic        tick_d;
    logic [2:0]  qcnt_q;
    logic [2:0]  qcnt_d;
    logic        queue_go;

    always_comb
    begin
        tick_cnt_d = tick_cnt_q + 32'h00000001;
        tick_d     = 1'b0;
        if (tick_cnt_q == 32'(SERVO_CYCLES - 1))
        begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
        qcnt_d = tick_q ? 3'(qcnt_q + 3'h1) : qcnt_q;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            qcnt_q     <= '0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            qcnt_q     <= qcnt_d;
        end
    end

    // ------------------------------------------------------------
    // Settings, TTL, loop close and read port
    // ------------------------------------------------------------
    logic [6:0]  ctrl_q;
    logic [6:0]  ctrl_d;
    logic [9:0]  tc_q;
    logic [9:0]  tc_d;
    logic [31:0] limit_q;
    logic [31:0] limit_d;
    logic [23:0] ttl_in_q;
    logic [7:0]  ttl_out_q;
    logic [7:0]  ttl_out_d;
    logic        wait_q;
    logic        wait_d;
    logic        close_pend_q;
    logic        close_pend_d;
    logic        loop_q;
    logic        loop_d;
    logic        ok_q;
    logic        ok_d;
    logic        refused_q;
    logic        refused_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  axis;
    logic [1:0]  fb_kind;
    logic        ttl_ok;
    logic        ref_ok;
    logic        fastq;
    logic [31:0] ref_pos_q;
    logic        ref_valid_q;
    logic        wr_ctrl;

    assign axis     = ctrl_q[afmf_pkg::CTRL_AXIS_LSB +: 2];
    assign fb_kind  = ctrl_q[afmf_pkg::CTRL_FB_LSB +: 2];
    assign fastq    = ctrl_q[afmf_pkg::CTRL_FASTQ_BIT];
    assign ttl_ok   = (axis == afmf_pkg::AXIS_SERVO);
    assign ref_ok   = (axis != afmf_pkg::AXIS_STEPPER);
    // Slow queuing only looks at pending events every eighth interrupt
    assign queue_go = tick_q && (fastq || qcnt_q == 3'(afmf_pkg::SLOW_QUEUE_TICKS - 1));
    assign wr_ctrl  = wr_i && addr_i == afmf_pkg::SV_CTRL;

    always_comb
    begin
        ctrl_d       = wr_ctrl ? wdata_i[afmf_pkg::CTRL_W-1:0] : ctrl_q;
        tc_d         = tc_q;
        limit_d      = limit_q;
        ttl_out_d    = ttl_out_q;
        close_pend_d = close_pend_q;
        loop_d       = loop_q;
        ok_d         = ok_q;
        refused_d    = refused_q;
        rdata_d      = '0;
        wait_d       = ttl_ok && ctrl_q[afmf_pkg::CTRL_VMODE_BIT]
                       && !ttl_in_q[afmf_pkg::VALID_BIT];
        if (!ttl_ok)
            ttl_out_d = '0;
        if (wr_i && addr_i == afmf_pkg::SV_TTL && ttl_ok)
            ttl_out_d = wdata_i[afmf_pkg::TTL_OUT_W-1:0];
        if (wr_i && addr_i == afmf_pkg::SV_FILT_TC)
            tc_d = wdata_i[afmf_pkg::TC_W-1:0];
        if (wr_i && addr_i == afmf_pkg::SV_FILT_LIM)
        begin
            // Zero is pulled up to the minimum, any value with bit 31 set to the maximum
            if (wdata_i[31])
                limit_d = afmf_pkg::LIMIT_MAX;
            else if (wdata_i == '0)
                limit_d = afmf_pkg::LIMIT_MIN;
            else
                limit_d = wdata_i;
        end
        // A request is acted on at the queue strobe, like a move start
        if (queue_go && close_pend_q)
        begin
            close_pend_d = 1'b0;
            loop_d       = !wait_q;
            ok_d         = !wait_q;
            refused_d    = wait_q;
        end
        if (wr_i && addr_i == afmf_pkg::SV_CLOSE)
        begin
            if (wdata_i[afmf_pkg::CLOSE_REQ_BIT])
            begin
                close_pend_d = 1'b1;
                ok_d         = 1'b0;
                refused_d    = 1'b0;
            end
            else
            begin
                close_pend_d = 1'b0;
                loop_d       = 1'b0;
            end
        end
        if (rd_i)
        begin
            unique case (addr_i)
                afmf_pkg::SV_TTL:
                    if (ttl_ok)
                        rdata_d = {wait_q, 7'h00, ttl_in_q};
                afmf_pkg::SV_REF_POS:
                    rdata_d = ref_pos_q;
                afmf_pkg::SV_FILT_TC:
                    rdata_d = {22'h0, tc_q};
                afmf_pkg::SV_FILT_LIM:
                    rdata_d = limit_q;
                afmf_pkg::SV_CTRL:
                    rdata_d = {25'h0, ctrl_q};
                afmf_pkg::SV_STATUS:
                    rdata_d = {26'h0, close_pend_q, ref_valid_q, refused_q, ok_q,
                               loop_q, wait_q};
                default:
                    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ctrl_q       <= afmf_pkg::CTRL_RESET;
            tc_q         <= afmf_pkg::TC_RESET;
            limit_q      <= afmf_pkg::LIMIT_RESET;
            ttl_in_q     <= '0;
            ttl_out_q    <= '0;
            wait_q       <= 1'b0;
            close_pend_q <= 1'b0;
            loop_q       <= 1'b0;
            ok_q         <= 1'b0;
            refused_q    <= 1'b0;
            rdata_q      <= '0;
        end
        else
        begin
            ctrl_q       <= ctrl_d;
            tc_q         <= tc_d;
            limit_q      <= limit_d;
            ttl_in_q     <= ttl_in_i;
            ttl_out_q    <= ttl_out_d;
            wait_q       <= wait_d;
            close_pend_q <= close_pend_d;
            loop_q       <= loop_d;
            ok_q         <= ok_d;
            refused_q    <= refused_d;
            rdata_q      <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Reference switch capture
    // ------------------------------------------------------------
    afmf_pkg::afmf_ref_state_t ref_st_q;
    afmf_pkg::afmf_ref_state_t ref_st_d;
    logic        sw_q;
    logic        idx_q;
    logic        sw_pend_q;
    logic        sw_pend_d;
    logic        idx_pend_q;
    logic        idx_pend_d;
    logic [31:0] start_q;
    logic [31:0] start_d;
    logic [31:0] ref_pos_d;
    logic        ref_valid_d;
    logic [31:0] pos_n;

    always_comb
    begin
        pos_n       = afmf_pkg::afmf_fb_norm(fb_pos_i, ctrl_q[afmf_pkg::CTRL_POL_BIT]);
        ref_st_d    = ref_st_q;
        start_d     = start_q;
        ref_pos_d   = ref_pos_q;
        ref_valid_d = ref_valid_q;
        sw_pend_d   = sw_pend_q;
        idx_pend_d  = idx_pend_q;
        if (queue_go)
        begin
            unique case (ref_st_q)
                afmf_pkg::REF_WAIT_SW:
                    if (sw_pend_q && ref_ok)
                    begin
                        sw_pend_d = 1'b0;
                        if (fb_kind == afmf_pkg::FB_ENCODER)
                        begin
                            start_d    = pos_n;
                            idx_pend_d = 1'b0;
                            ref_st_d   = afmf_pkg::REF_WAIT_IDX;
                        end
                        else
                        begin
                            ref_pos_d   = pos_n;
                            ref_valid_d = 1'b1;
                            ref_st_d    = afmf_pkg::REF_LATCHED;
                        end
                    end
                afmf_pkg::REF_WAIT_IDX:
                    if (idx_pend_q)
                    begin
                        idx_pend_d  = 1'b0;
                        ref_pos_d   = 32'(pos_n - start_q);
                        ref_valid_d = 1'b1;
                        ref_st_d    = afmf_pkg::REF_LATCHED;
                    end
                afmf_pkg::REF_LATCHED:
                    if (!sw_q)
                        ref_st_d = afmf_pkg::REF_WAIT_SW;
            endcase
        end
        // New edges win over the clear at the strobe
        if (ref_switch_i && !sw_q)
            sw_pend_d = 1'b1;
        if (index_mark_i && !idx_q)
            idx_pend_d = 1'b1;
        if (!ref_ok)
        begin
            ref_st_d    = afmf_pkg::REF_WAIT_SW;
            ref_valid_d = 1'b0;
            ref_pos_d   = '0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ref_st_q    <= afmf_pkg::REF_WAIT_SW;
            sw_q        <= 1'b0;
            idx_q       <= 1'b0;
            sw_pend_q   <= 1'b0;
            idx_pend_q  <= 1'b0;
            start_q     <= '0;
            ref_pos_q   <= '0;
            ref_valid_q <= 1'b0;
        end
        else
        begin
            ref_st_q    <= ref_st_d;
            sw_q        <= ref_switch_i;
            idx_q       <= index_mark_i;
            sw_pend_q   <= sw_pend_d;
            idx_pend_q  <= idx_pend_d;
            start_q     <= start_d;
            ref_pos_q   <= ref_pos_d;
            ref_valid_q <= ref_valid_d;
        end
    end

    // ------------------------------------------------------------
    // Slave master delta filter
    // ------------------------------------------------------------
    afmf_master_filter u_filter (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .tick_i  (tick_q),
        .tc_i    (tc_q),
        .limit_i (limit_q),
        .delta_i (master_delta_i),
        .out_o   (slave_delta_o)
    );

    assign rdata_o       = rdata_q;
    assign ttl_out_o     = ttl_out_q;
    assign loop_closed_o = loop_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_ttl_read_low: assert property (
        rd_i && addr_i == afmf_pkg::SV_TTL && ttl_ok
        |=> rdata_o[23:0] == $past(ttl_in_q) && rdata_o[30:24] == 7'h00)
        else $error("TTL read did not return the sampled inputs");

    a_wait_flag_msb: assert property (
        rd_i && addr_i == afmf_pkg::SV_TTL && ttl_ok && wait_q |=> rdata_o[31])
        else $error("waiting flag missing from bit 31");

    a_wait_clears: assert property (
        ttl_in_q[afmf_pkg::VALID_BIT] && !wr_ctrl |=> !wait_q)
        else $error("waiting flag stayed high after valid data");

    a_close_refused: assert property (
        queue_go && close_pend_q && wait_q && !(wr_i && addr_i == afmf_pkg::SV_CLOSE)
        |=> !loop_closed_o && refused_q && !ok_q)
        else $error("loop closed while waiting for valid data");

    a_ttl_out_write: assert property (
        wr_i && addr_i == afmf_pkg::SV_TTL && ttl_ok |=> ttl_out_o == $past(wdata_i[7:0]))
        else $error("TTL outputs not taken from written data");

    a_ttl_hidden: assert property (
        rd_i && addr_i == afmf_pkg::SV_TTL && !ttl_ok |=> rdata_o == '0 && ttl_out_o == '0)
        else $error("TTL feature visible on a stepper or SERCOS axis");

    a_stepper_no_ref: assert property (
        !ref_ok |=> !ref_valid_q && ref_pos_q == '0)
        else $error("reference captured on a stepper axis");

    a_fast_queue: assert property (
        tick_q && fastq && close_pend_q && !(wr_i && addr_i == afmf_pkg::SV_CLOSE)
        |=> !close_pend_q)
        else $error("fast queuing left a close request waiting");

    a_resolver_ref: assert property (
        queue_go && ref_ok && ref_st_q == afmf_pkg::REF_WAIT_SW && sw_pend_q
        && fb_kind == afmf_pkg::FB_RESOLVER
        |=> ref_valid_q && ref_pos_q == $past(pos_n) ##1 ref_st_q == afmf_pkg::REF_LATCHED
            || !ref_ok)
        else $error("resolver reference not captured at switch closure");

endmodule // afmf_axis_feedback

`default_nettype wire

// ### tb/afmf_ttl_dev.sv
// Model of the parallel TTL position source
`default_nettype none
module afmf_ttl_dev (
    // Clock and control
    input  wire logic        clock_i,
    input  wire logic        ready_i,
    input  wire logic [22:0] pos_i,
    // TTL lines
    output logic      [23:0] ttl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [22:0] junk_q = 23'h0;
    // Junk toggles while not valid so it never passes for a position
    always_ff @(posedge clock_i)
        junk_q <= ~junk_q;
    assign ttl_o = ready_i ? {1'b1, pos_i} : {1'b0, junk_q};
endmodule // afmf_ttl_dev
`default_nettype wire

// ### tb/testbench.sv
// Bench for the axis feedback and master filter
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [23:0] ttl_in_i;
    logic [7:0]  ttl_out_o;
    logic        ref_switch_i = 1'b0;
    logic        index_mark_i = 1'b0;
    logic [31:0] fb_pos_i = 32'h0;
    logic [31:0] master_delta_i = 32'h0;
    logic [31:0] slave_delta_o;
    logic        loop_closed_o;
    logic        ready = 1'b0;
    logic [31:0] v;
    int          bad_count = 0;
    int          samples_checked = 0;

    afmf_axis_feedback #(.SERVO_CYCLES(20)) i_afmf_axis_feedback (
        .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ttl_in_i(ttl_in_i),
        .ttl_out_o(ttl_out_o), .ref_switch_i(ref_switch_i), .index_mark_i(index_mark_i),
        .fb_pos_i(fb_pos_i), .master_delta_i(master_delta_i),
        .slave_delta_o(slave_delta_o), .loop_closed_o(loop_closed_o));
    afmf_ttl_dev i_afmf_ttl_dev (.clock_i(clock_i), .ready_i(ready),
        .pos_i(23'h12345), .ttl_o(ttl_in_i));

    initial
    begin
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe; taken at the edge closing it
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
        v = rdata_o;
    endtask

    task automatic t_ttl();
        ready <= 1'b1;
        wr(8'h1C, 32'h000001A5);
        wt(1);
        chk({24'h0, ttl_out_o}, 32'h000000A5);
        rd(8'h1C);
        chk(v, 32'h00812345);
    endtask

    task automatic t_wait();
        ready <= 1'b0;
        wr(8'h28, 32'h0000006C);
        wt(3);
        rd(8'h1C);
        chk({31'h0, v[31]}, 32'h1);
        wr(8'h2A, 32'h1);
        wt(50);
        chk({31'h0, loop_closed_o}, 32'h0);
        rd(8'h29);
        chk({31'h0, v[3]}, 32'h1);
        ready <= 1'b1;
        wt(3);
        rd(8'h1C);
        chk({31'h0, v[31]}, 32'h0);
        wr(8'h2A, 32'h1);
        wt(50);
        chk({31'h0, loop_closed_o}, 32'h1);
    endtask

    task automatic t_step();
        wr(8'h28, 32'h00000001);
        wr(8'h1C, 32'h000000FF);
        wt(1);
        chk({24'h0, ttl_out_o}, 32'h0);
        rd(8'h1C);
        chk(v, 32'h0);
    endtask

    // Resolver with inverted polarity reads the position negated
    task automatic t_ref();
        wr(8'h28, 32'h00000034);
        fb_pos_i <= 32'd100;
        wt(2);
        ref_switch_i <= 1'b1;
        wt(50);
        rd(8'h1D);
        chk(v, 32'hFFFFFF9C);
        ref_switch_i <= 1'b0;
    endtask

    // Encoder measures switch to index, analog latches absolute, stepper shows none
    task automatic t_enc();
        wr(8'h28, 32'h00000020);
        wt(25);
        fb_pos_i <= 32'h64;
        ref_switch_i <= 1'b1;
        wt(25);
        fb_pos_i <= 32'h82;
        index_mark_i <= 1'b1;
        wt(25);
        rd(8'h1D);
        chk(v, 32'h1E);
        ref_switch_i <= 1'b0;
        index_mark_i <= 1'b0;
        wr(8'h28, 32'h00000028);
        wt(25);
        fb_pos_i <= 32'h4D;
        ref_switch_i <= 1'b1;
        wt(25);
        rd(8'h1D);
        chk(v, 32'h4D);
        ref_switch_i <= 1'b0;
        wr(8'h28, 32'h00000021);
        rd(8'h1D);
        chk(v, 32'h0);
    endtask

    task automatic t_filt();
        wr(8'h28, 32'h0);
        wr(8'h1E, 32'h0);
        master_delta_i <= 32'd5;
        wt(50);
        chk(slave_delta_o, 32'h5);
        wr(8'h1E, 32'h200);
        wr(8'h1F, 32'h3);
        master_delta_i <= 32'd10;
        wt(100);
        chk(slave_delta_o, 32'hA);
        master_delta_i <= 32'hFFFFFFF6;
        wt(100);
        chk(slave_delta_o, 32'hFFFFFFF6);
    endtask

    // Fresh reset so the lag starts at zero; time constant 3 acts as a divide by 4
    task automatic t_shift();
        reset_i <= 1'b1;
        master_delta_i <= 32'h3E8;
        wt(6);
        reset_i <= 1'b0;
        wt(50);
        chk(slave_delta_o, 32'h3E8);
        wr(8'h1E, 32'h3);
        for (int i = 0; i < 40 && slave_delta_o == 32'h3E8; i++)
            wt(1);
        chk(slave_delta_o, 32'hFA);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #20us;
        bad_count++;
        results();
    end

    initial
    begin
        wt(6);
        reset_i <= 1'b0;
        wt(1);
        t_ttl();
        t_wait();
        t_step();
        t_ref();
        t_enc();
        t_filt();
        t_shift();
        results();
    end
endmodule // testbench
`default_nettype wire
